/* crtrt_pkg.sv */
// constants for the crt raster timing controller
// Functional notes
// - non-interlace: scanline address counts up from zero
// - interlace sync: same scanlines both fields
// - sync-video even rows: field picks parity of the first row, later rows start at zero
// - sync-video odd rows: parity swaps per row
// - 5-bit index selects register; 8..13 ignored
// - select high reaches indexed control register
// - hsync position is start minus one
// - low nibble sets hsync width, never zero
// - high nibble sets vsync width, zero gives 16
// - vertical adjust adds extra rasters per field
// - vsync position is start row minus one
// - bits 1:0 select scan mode
// - bits 5:4 skew or suppress display enable
// - bits 7:6 skew or suppress cursor
// - max scanline wraps raster, advances row
// - cursor start line plus blink mode
// - cursor end line bounds the cursor band
// - frame addressing starts at start address
// - cursor asserted at matching address in band
// - pen capture pair is read only
// - pen strobe rising edge latches refresh address
package crtrt_pkg;
  localparam logic [4:0] IDX_HTOTAL  = 5'h00;
  localparam logic [4:0] IDX_HDISP   = 5'h01;
  localparam logic [4:0] IDX_HSPOS   = 5'h02;
  localparam logic [4:0] IDX_SYNCW   = 5'h03;
  localparam logic [4:0] IDX_VTOTAL  = 5'h04;
  localparam logic [4:0] IDX_VADJ    = 5'h05;
  localparam logic [4:0] IDX_VDISP   = 5'h06;
  localparam logic [4:0] IDX_VSPOS   = 5'h07;
  localparam logic [4:0] IDX_MODE    = 5'h08;
  localparam logic [4:0] IDX_MAXSL   = 5'h09;
  localparam logic [4:0] IDX_CSTART  = 5'h0a;
  localparam logic [4:0] IDX_CEND    = 5'h0b;
  localparam logic [4:0] IDX_SAHI    = 5'h0c;
  localparam logic [4:0] IDX_SALO    = 5'h0d;
  localparam logic [4:0] IDX_CLHI    = 5'h0e;
  localparam logic [4:0] IDX_CLLO    = 5'h0f;
  localparam logic [4:0] IDX_PENHI   = 5'h10;
  localparam logic [4:0] IDX_PENLO   = 5'h11;
  localparam logic [4:0] IDX_IGN_LO  = 5'h08;
  localparam logic [4:0] IDX_IGN_HI  = 5'h0d;
  localparam logic [1:0] SKEW_NONE   = 2'h0;
  localparam logic [1:0] SKEW_ONE    = 2'h1;
  localparam logic [1:0] SKEW_TWO    = 2'h2;
  localparam logic [1:0] SKEW_OFF    = 2'h3;
  localparam logic [1:0] MODE_NONIL  = 2'h0;
  localparam logic [1:0] MODE_ILSYNC = 2'h1;
  localparam logic [1:0] MODE_ILVID  = 2'h3;
  localparam logic [1:0] CUR_STEADY  = 2'h0;
  localparam logic [1:0] CUR_HIDDEN  = 2'h1;
  localparam logic [1:0] CUR_BLINK16 = 2'h2;
  localparam logic [1:0] CUR_BLINK32 = 2'h3;
  localparam logic [4:0] VSW_ZERO_AS = 5'h10;
  localparam int         BLINK_BIT16 = 3;
  localparam int         BLINK_BIT32 = 4;
  typedef enum logic [2:0] {
    VS_ACTIVE = 3'b001,
    VS_ADJUST = 3'b010,
    VS_NEWFRM = 3'b100
  } crtrt_vstate_t;
endpackage

/* crtrt_top.sv */
// crt raster timing generator with indexed register file
`timescale 1ns/1ps
`default_nettype none
module crtrt_top #(
  parameter int ADDR_W = 14
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              chipSelectN,
  input  wire logic              registerSelect,
  input  wire logic              readNotWrite,
  input  wire logic              busStrobe,
  input  wire logic [7:0]        dataIn,
  output logic      [7:0]        dataOut,
  output logic                   dataOe,
  input  wire logic              penStrobe,
  output logic                   hsync,
  output logic                   vsync,
  output logic                   displayEnable,
  output logic                   cursor,
  output logic [ADDR_W-1:0]      refreshAddress,
  output logic [4:0]             scanlineAddress
);
  initial begin
    if (ADDR_W != 14) $error("crtrt_top supports ADDR_W 14 only");
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [4:0] regIndex_q;
  logic [7:0] hTotal_q, hDisp_q, hsPos_q, syncW_q, modeSkew_q, saHi_q, saLo_q, clHi_q, clLo_q;
  logic [6:0] vTotal_q, vDisp_q, vsPos_q, cStart_q;
  logic [4:0] vAdj_q, maxSl_q, cEnd_q;
  logic [13:0] pen_q;

  wire accessNow  = busStrobe & ~chipSelectN;
  wire writeIdx   = accessNow & ~registerSelect & ~readNotWrite;
  wire writeData  = accessNow & registerSelect & ~readNotWrite;
  wire idxIgnored = (dataIn[4:0] >= crtrt_pkg::IDX_IGN_LO) && (dataIn[4:0] <= crtrt_pkg::IDX_IGN_HI);

  function automatic logic hit(input logic [4:0] idx);
    hit = writeData && (regIndex_q == idx);
  endfunction

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regIndex_q <= 5'h00;
    end else if (writeIdx && !idxIgnored) begin
      regIndex_q <= dataIn[4:0];
    end
  end

  // data writes go to indexed register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hTotal_q <= 8'h00; hDisp_q <= 8'h00; hsPos_q <= 8'h00; syncW_q <= 8'h00;
      vTotal_q <= 7'h00; vAdj_q <= 5'h00; vDisp_q <= 7'h00; vsPos_q <= 7'h00;
      modeSkew_q <= 8'h00; maxSl_q <= 5'h00; cStart_q <= 7'h00; cEnd_q <= 5'h00;
      saHi_q <= 8'h00; saLo_q <= 8'h00; clHi_q <= 8'h00; clLo_q <= 8'h00;
    end else begin
      if (hit(crtrt_pkg::IDX_HTOTAL)) hTotal_q <= dataIn;
      if (hit(crtrt_pkg::IDX_HDISP))  hDisp_q <= dataIn;
      if (hit(crtrt_pkg::IDX_HSPOS))  hsPos_q <= dataIn;
      if (hit(crtrt_pkg::IDX_SYNCW))  syncW_q <= dataIn;
      if (hit(crtrt_pkg::IDX_VTOTAL)) vTotal_q <= dataIn[6:0];
      if (hit(crtrt_pkg::IDX_VADJ))   vAdj_q <= dataIn[4:0];
      if (hit(crtrt_pkg::IDX_VDISP))  vDisp_q <= dataIn[6:0];
      if (hit(crtrt_pkg::IDX_VSPOS))  vsPos_q <= dataIn[6:0];
      if (hit(crtrt_pkg::IDX_MODE))   modeSkew_q <= dataIn;
      if (hit(crtrt_pkg::IDX_MAXSL))  maxSl_q <= dataIn[4:0];
      if (hit(crtrt_pkg::IDX_CSTART)) cStart_q <= dataIn[6:0];
      if (hit(crtrt_pkg::IDX_CEND))   cEnd_q <= dataIn[4:0];
      // top two high bits stay zero
      if (hit(crtrt_pkg::IDX_SAHI))   saHi_q <= {2'b00, dataIn[5:0]};
      if (hit(crtrt_pkg::IDX_SALO))   saLo_q <= dataIn;
      if (hit(crtrt_pkg::IDX_CLHI))   clHi_q <= {2'b00, dataIn[5:0]};
      if (hit(crtrt_pkg::IDX_CLLO))   clLo_q <= dataIn;
    end
  end

  // read mux, pen pair read only
  logic [7:0] readMux;
  always_comb begin
    unique case (regIndex_q)
      crtrt_pkg::IDX_HTOTAL: readMux = hTotal_q;
      crtrt_pkg::IDX_HDISP:  readMux = hDisp_q;
      crtrt_pkg::IDX_HSPOS:  readMux = hsPos_q;
      crtrt_pkg::IDX_SYNCW:  readMux = syncW_q;
      crtrt_pkg::IDX_VTOTAL: readMux = {1'b0, vTotal_q};
      crtrt_pkg::IDX_VADJ:   readMux = {3'b000, vAdj_q};
      crtrt_pkg::IDX_VDISP:  readMux = {1'b0, vDisp_q};
      crtrt_pkg::IDX_VSPOS:  readMux = {1'b0, vsPos_q};
      crtrt_pkg::IDX_MODE:   readMux = modeSkew_q;
      crtrt_pkg::IDX_MAXSL:  readMux = {3'b000, maxSl_q};
      crtrt_pkg::IDX_CSTART: readMux = {1'b0, cStart_q};
      crtrt_pkg::IDX_CEND:   readMux = {3'b000, cEnd_q};
      crtrt_pkg::IDX_SAHI:   readMux = saHi_q;
      crtrt_pkg::IDX_SALO:   readMux = saLo_q;
      crtrt_pkg::IDX_CLHI:   readMux = clHi_q;
      crtrt_pkg::IDX_CLLO:   readMux = clLo_q;
      crtrt_pkg::IDX_PENHI:  readMux = {2'b00, pen_q[13:8]};
      crtrt_pkg::IDX_PENLO:  readMux = pen_q[7:0];
      default:               readMux = 8'h00;
    endcase
  end

  wire readData = accessNow & registerSelect & readNotWrite;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dataOut <= 8'h00;
      dataOe  <= 1'b0;
    end else begin
      dataOut <= readData ? readMux : 8'h00;
      dataOe  <= readData;
    end
  end

  // ----------------------------------------
  // horizontal timing
  // ----------------------------------------
  logic [7:0] hCnt_q;
  logic [3:0] hsCnt_q;
  logic       hsActive_q;
  wire        lineEnd = (hCnt_q == hTotal_q);
  wire        hDispOn = (hCnt_q < hDisp_q);
  wire        hsStart = (hCnt_q == hsPos_q);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hCnt_q <= 8'h00;
      hsCnt_q <= 4'h0;
      hsActive_q <= 1'b0;
    end else begin
      hCnt_q <= lineEnd ? 8'h00 : hCnt_q + 8'h01;
      if (hsStart) begin
        hsActive_q <= 1'b1;
        hsCnt_q <= 4'h1;
      end else if (hsActive_q && hsCnt_q >= syncW_q[3:0]) begin
        hsActive_q <= 1'b0;
      end else if (hsActive_q) begin
        hsCnt_q <= hsCnt_q + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // vertical timing
  // ----------------------------------------
  crtrt_pkg::crtrt_vstate_t vState_q;
  logic [4:0] rasterCnt_q, adjCnt_q, vsCnt_q;
  logic [6:0] rowCnt_q;
  logic       field_q, vsActive_q;
  logic [4:0] frameCnt_q;
  logic [13:0] rowBase_q, addr_q;

  wire [1:0] scanMode = modeSkew_q[1:0];
  wire       ilVideo  = (scanMode == crtrt_pkg::MODE_ILVID);
  // sync-video steps two rasters per line
  wire [4:0] rasterStep = ilVideo ? 5'h02 : 5'h01;
  wire       rowEnd   = ilVideo ? (rasterCnt_q + 5'h01 >= maxSl_q) : (rasterCnt_q == maxSl_q);
  wire       lastRow  = (rowCnt_q == vTotal_q);
  wire       adjDone  = (adjCnt_q + 5'h01 >= vAdj_q);
  wire       vDispOn  = (rowCnt_q < vDisp_q) && (vState_q == crtrt_pkg::VS_ACTIVE);
  wire [4:0] vswWidth = (syncW_q[7:4] == 4'h0) ? crtrt_pkg::VSW_ZERO_AS : {1'b0, syncW_q[7:4]};
  wire       vsStart  = lineEnd && rowEnd && (rowCnt_q == vsPos_q) && (vState_q == crtrt_pkg::VS_ACTIVE);
  // next field follows the last raster with no idle line between
  wire       newFrame = (vState_q == crtrt_pkg::VS_NEWFRM) ||
                        (vState_q == crtrt_pkg::VS_ACTIVE && rowEnd && lastRow && vAdj_q == 5'h00) ||
                        (vState_q == crtrt_pkg::VS_ADJUST && adjDone);
  // parity of the first raster: every row for odd rows, only the first row for even rows
  wire       oddTrn   = maxSl_q[0] == 1'b0;
  wire       startOdd = ilVideo && (oddTrn ? (field_q ^ rowCnt_q[0]) : field_q);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vState_q <= crtrt_pkg::VS_NEWFRM;
      rasterCnt_q <= 5'h00; rowCnt_q <= 7'h00; adjCnt_q <= 5'h00;
      field_q <= 1'b0; frameCnt_q <= 5'h00; vsActive_q <= 1'b0; vsCnt_q <= 5'h00;
    end else if (lineEnd) begin
      if (vsStart) begin
        vsActive_q <= 1'b1;
        vsCnt_q <= 5'h01;
      end else if (vsActive_q && vsCnt_q >= vswWidth) begin
        vsActive_q <= 1'b0;
      end else if (vsActive_q) begin
        vsCnt_q <= vsCnt_q + 5'h01;
      end
      unique case (vState_q)
        crtrt_pkg::VS_ACTIVE: begin
          if (rowEnd) begin
            rowCnt_q <= rowCnt_q + 7'h01;
            rasterCnt_q <= (ilVideo && oddTrn && (field_q ^ ~rowCnt_q[0])) ? 5'h01 : 5'h00;
            if (lastRow) begin
              adjCnt_q <= 5'h00;
              if (vAdj_q != 5'h00) vState_q <= crtrt_pkg::VS_ADJUST;
            end
          end else begin
            rasterCnt_q <= rasterCnt_q + rasterStep;
          end
        end
        crtrt_pkg::VS_ADJUST: begin
          adjCnt_q <= adjCnt_q + 5'h01;
        end
        crtrt_pkg::VS_NEWFRM: begin
          vState_q <= crtrt_pkg::VS_ACTIVE;
        end
        default: vState_q <= crtrt_pkg::VS_NEWFRM;
      endcase
      // frame is rows plus adjust rasters only
      if (newFrame) begin
        vState_q <= crtrt_pkg::VS_ACTIVE;
        rowCnt_q <= 7'h00;
        field_q <= (scanMode == crtrt_pkg::MODE_NONIL) ? 1'b0 : ~field_q;
        frameCnt_q <= frameCnt_q + 5'h01;
        rasterCnt_q <= (ilVideo && !field_q) ? 5'h01 : 5'h00;
      end
    end
  end

  // ----------------------------------------
  // refresh addressing
  // ----------------------------------------
  wire [13:0] startAddr = {saHi_q[5:0], saLo_q};
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rowBase_q <= 14'h0000;
      addr_q <= 14'h0000;
    end else if (lineEnd) begin
      if (newFrame) begin
        rowBase_q <= startAddr;
        addr_q <= startAddr;
      end else if (vState_q == crtrt_pkg::VS_ACTIVE && rowEnd) begin
        rowBase_q <= rowBase_q + {6'h00, hDisp_q};
        addr_q <= rowBase_q + {6'h00, hDisp_q};
      end else begin
        addr_q <= rowBase_q;
      end
    end else begin
      addr_q <= addr_q + 14'h0001;
    end
  end

  // ----------------------------------------
  // cursor, skew, light pen
  // ----------------------------------------
  wire [4:0] rasterOut = (vState_q == crtrt_pkg::VS_ACTIVE) ? rasterCnt_q : adjCnt_q;
  wire [1:0] curMode   = cStart_q[6:5];
  wire       blinkOn   = (curMode == crtrt_pkg::CUR_STEADY) ||
                         (curMode == crtrt_pkg::CUR_BLINK16 && frameCnt_q[crtrt_pkg::BLINK_BIT16]) ||
                         (curMode == crtrt_pkg::CUR_BLINK32 && frameCnt_q[crtrt_pkg::BLINK_BIT32]);
  wire       curRaw    = blinkOn && (addr_q == {clHi_q[5:0], clLo_q}) &&
                         (rasterOut >= cStart_q[4:0]) && (rasterOut <= cEnd_q);
  wire       deRaw     = hDispOn && vDispOn;

  logic [1:0] deDly_q, curDly_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      deDly_q <= 2'b00;
      curDly_q <= 2'b00;
    end else begin
      deDly_q <= {deDly_q[0], deRaw};
      curDly_q <= {curDly_q[0], curRaw & deRaw};
    end
  end

  function automatic logic skewSel(input logic [1:0] sel, input logic now, input logic [1:0] dly);
    unique case (sel)
      crtrt_pkg::SKEW_NONE: skewSel = now;
      crtrt_pkg::SKEW_ONE:  skewSel = dly[0];
      crtrt_pkg::SKEW_TWO:  skewSel = dly[1];
      default:              skewSel = 1'b0;
    endcase
  endfunction

  wire deSkew  = skewSel(modeSkew_q[5:4], deRaw, deDly_q);
  wire curSkew = skewSel(modeSkew_q[7:6], curRaw & deRaw, curDly_q);

  // pen strobe from a pin: two flops first
  logic penS1_q, penS2_q, penS3_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      penS1_q <= 1'b0; penS2_q <= 1'b0; penS3_q <= 1'b0; pen_q <= 14'h0000;
    end else begin
      penS1_q <= penStrobe;
      penS2_q <= penS1_q;
      penS3_q <= penS2_q;
      if (penS2_q && !penS3_q) pen_q <= addr_q;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hsync <= 1'b0; vsync <= 1'b0; displayEnable <= 1'b0; cursor <= 1'b0;
      refreshAddress <= '0; scanlineAddress <= 5'h00;
    end else begin
      hsync <= hsActive_q;
      vsync <= vsActive_q;
      displayEnable <= deSkew;
      cursor <= curSkew & deSkew;
      refreshAddress <= addr_q;
      scanlineAddress <= rasterOut;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_idx_gap;
    @(posedge core_clk) disable iff (rst) (writeIdx && idxIgnored) |=> $stable(regIndex_q);
  endproperty
  a_idx_gap: assert property (p_idx_gap) else $error("ignored index changed");
  property p_hi_zero;
    @(posedge core_clk) disable iff (rst) saHi_q[7:6] == 2'b00 && clHi_q[7:6] == 2'b00;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("address high bits not zero");
  property p_de_off;
    @(posedge core_clk) disable iff (rst) (modeSkew_q[5:4] == crtrt_pkg::SKEW_OFF) |=> !displayEnable;
  endproperty
  a_de_off: assert property (p_de_off) else $error("suppressed enable seen");
  property p_cur_de;
    @(posedge core_clk) disable iff (rst) cursor |-> displayEnable;
  endproperty
  a_cur_de: assert property (p_cur_de) else $error("cursor without enable");
  property p_pen;
    @(posedge core_clk) disable iff (rst) (penS2_q && !penS3_q) |=> pen_q == $past(addr_q);
  endproperty
  a_pen: assert property (p_pen) else $error("pen capture wrong");
  property p_wrap;
    @(posedge core_clk) disable iff (rst)
      (lineEnd && rowEnd && vState_q == crtrt_pkg::VS_ACTIVE && !lastRow) |=> rowCnt_q == $past(rowCnt_q) + 7'h01;
  endproperty
  a_wrap: assert property (p_wrap) else $error("row not advanced");
  property p_nonil;
    @(posedge core_clk) disable iff (rst)
      (lineEnd && !rowEnd && vState_q == crtrt_pkg::VS_ACTIVE && scanMode == crtrt_pkg::MODE_NONIL)
      |=> rasterCnt_q == $past(rasterCnt_q) + 5'h01;
  endproperty
  a_nonil: assert property (p_nonil) else $error("raster step wrong");
  property p_data_wr;
    @(posedge core_clk) disable iff (rst) hit(crtrt_pkg::IDX_HDISP) |=> hDisp_q == $past(dataIn);
  endproperty
  a_data_wr: assert property (p_data_wr) else $error("indexed write lost");
  property p_vs_start;
    @(posedge core_clk) disable iff (rst) vsStart |=> vsActive_q;
  endproperty
  a_vs_start: assert property (p_vs_start) else $error("vsync not started");
  property p_frame_start;
    @(posedge core_clk) disable iff (rst) (lineEnd && newFrame) |=> addr_q == $past(startAddr);
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame start address wrong");
  c_frame: cover property (@(posedge core_clk) disable iff (rst) vState_q == crtrt_pkg::VS_ADJUST);
  c_vsync: cover property (@(posedge core_clk) disable iff (rst) $rose(vsync));
  c_cursor: cover property (@(posedge core_clk) disable iff (rst) $rose(cursor));
  c_hsync: cover property (@(posedge core_clk) disable iff (rst) $rose(hsync));
endmodule // crtrt_top
`default_nettype wire

/* crtrt_crt_model.sv */
// display-side model: measures sync and enable timing, drives the pen strobe
`timescale 1ns/1ps
`default_nettype none
module crtrt_crt_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        hsync,
  input  wire logic        vsync,
  input  wire logic        displayEnable,
  input  wire logic        cursor,
  input  wire logic [13:0] refreshAddress,
  input  wire logic        penArm,
  input  wire logic [13:0] penTarget,
  output logic             penStrobe,
  output logic      [15:0] hsWidth,
  output logic      [15:0] hsPeriod,
  output logic      [15:0] hsLead,
  output logic      [15:0] vsWidth,
  output logic      [15:0] frPeriod,
  output logic      [15:0] deLine,
  output logic      [15:0] curFrame,
  output logic      [13:0] firstAddr,
  output logic             curBad,
  output logic      [15:0] frameCnt
);
  logic        hsQ, vsQ, deQ, newFrm, deSeen, hsRise, vsRise, deRise, deFall;
  logic [15:0] hsRun, hsGap, vsRun, frGap, deRun, curRun, leadRun;
  logic [2:0]  penCnt;
  assign hsRise = hsync & ~hsQ;
  assign vsRise = vsync & ~vsQ;
  assign deRise = displayEnable & ~deQ;
  assign deFall = deQ & ~displayEnable;
  assign penStrobe = (penCnt != 3'h0);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {hsQ, vsQ, deQ, newFrm, deSeen, curBad} <= '0;
      {hsRun, hsGap, vsRun, frGap, deRun, curRun, leadRun} <= '0;
      {hsWidth, hsPeriod, hsLead, vsWidth, frPeriod, deLine, curFrame, frameCnt} <= '0;
      firstAddr <= 14'h0;
      penCnt <= 3'h0;
    end else begin
      hsQ <= hsync;
      vsQ <= vsync;
      deQ <= displayEnable;
      hsRun <= hsync ? hsRun + 16'h1 : 16'h0;
      if (hsQ && !hsync) hsWidth <= hsRun;
      hsGap <= hsRise ? 16'h1 : hsGap + 16'h1;
      if (hsRise) hsPeriod <= hsGap;
      vsRun <= vsync ? vsRun + 16'h1 : 16'h0;
      if (vsQ && !vsync) vsWidth <= vsRun;
      frGap <= vsRise ? 16'h1 : frGap + 16'h1;
      curRun <= (vsRise ? 16'h0 : curRun) + {15'h0, cursor};
      if (vsRise) begin
        frPeriod <= frGap;
        frameCnt <= frameCnt + 16'h1;
        curFrame <= curRun;
        newFrm <= 1'b1;
      end else if (deRise && newFrm) begin
        firstAddr <= refreshAddress;
        newFrm <= 1'b0;
      end
      deRun <= displayEnable ? deRun + 16'h1 : 16'h0;
      if (deFall) deLine <= deRun;
      // lead only counts on lines that carried video
      leadRun <= deFall ? 16'h1 : leadRun + 16'h1;
      if (deFall) deSeen <= 1'b1;
      else if (hsRise) deSeen <= 1'b0;
      if (hsRise && deSeen) hsLead <= leadRun;
      if (cursor && !displayEnable) curBad <= 1'b1;
      if (penCnt != 3'h0) penCnt <= penCnt - 3'h1;
      else if (penArm && displayEnable && refreshAddress == penTarget) penCnt <= 3'h4;
    end
  end
endmodule // crtrt_crt_model
`default_nettype wire

/* crt_raster_timing_control_tb.sv */
// self-checking bench for the crt raster timing controller
`timescale 1ns/1ps
`default_nettype none
module crt_raster_timing_control_tb;
  logic        core_clk, rst, chipSelectN, registerSelect, readNotWrite, busStrobe;
  logic        dataOe, penStrobe, hsync, vsync, displayEnable, cursor, penArm, curBad;
  logic [7:0]  dataIn, dataOut, rdv;
  logic [13:0] refreshAddress, penTarget, firstAddr;
  logic [4:0]  scanlineAddress, vadj;
  logic [15:0] hsWidth, hsPeriod, hsLead, vsWidth, frPeriod, deLine, curFrame, frameCnt, cap;
  logic [31:0] r;
  logic [3:0]  hsync_width_field, vsync_width_field;
  int          nFail, checkCount, seed, i, k;

  crtrt_top uut (.core_clk(core_clk), .rst(rst), .chipSelectN(chipSelectN), .registerSelect(registerSelect),
    .readNotWrite(readNotWrite), .busStrobe(busStrobe), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
    .penStrobe(penStrobe), .hsync(hsync), .vsync(vsync), .displayEnable(displayEnable), .cursor(cursor),
    .refreshAddress(refreshAddress), .scanlineAddress(scanlineAddress));
  crtrt_crt_model crt (.core_clk(core_clk), .rst(rst), .hsync(hsync), .vsync(vsync),
    .displayEnable(displayEnable), .cursor(cursor), .refreshAddress(refreshAddress), .penArm(penArm),
    .penTarget(penTarget), .penStrobe(penStrobe), .hsWidth(hsWidth), .hsPeriod(hsPeriod), .hsLead(hsLead),
    .vsWidth(vsWidth), .frPeriod(frPeriod), .deLine(deLine), .curFrame(curFrame), .firstAddr(firstAddr),
    .curBad(curBad), .frameCnt(frameCnt));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  function automatic logic [7:0] reg_mask(input logic [4:0] idx);
    case (idx)
      5'h04, 5'h06, 5'h07: reg_mask = 8'h7f;
      5'h05:               reg_mask = 8'h1f;
      5'h0e:               reg_mask = 8'h3f;
      default:             reg_mask = 8'hff;
    endcase
  endfunction
  function automatic logic [15:0] exp_vs(input logic [3:0] w);
    exp_vs = (w == 4'h0) ? 16'd640 : {12'h0, w} * 16'd40;
  endfunction
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_count(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus_op(input logic rs, input logic rw, input logic [7:0] d);
    @(posedge core_clk);
    chipSelectN <= 1'b0;
    registerSelect <= rs;
    readNotWrite <= rw;
    dataIn <= d;
    busStrobe <= 1'b1;
    @(posedge core_clk);
    busStrobe <= 1'b0;
    chipSelectN <= 1'b1;
  endtask
  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    bus_op(1'b0, 1'b0, {3'h0, idx});
    bus_op(1'b1, 1'b0, d);
  endtask
  // read data lands one cycle after the strobe and stands one cycle
  task automatic get(input logic [4:0] idx);
    bus_op(1'b0, 1'b0, {3'h0, idx});
    bus_op(1'b1, 1'b1, 8'h00);
    #1;
    rdv = dataOut;
    chk_byte({7'h0, dataOe}, 8'h01);
    @(posedge core_clk);
    #1;
    chk_byte({7'h0, dataOe}, 8'h00);
  endtask
  task automatic rd(input logic [4:0] idx, input logic [7:0] exp);
    get(idx);
    chk_byte(rdv, exp);
  endtask
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic wait_frames(input int n);
    logic [15:0] f0;
    int          c;
    f0 = frameCnt;
    for (c = 0; c < 40000 && frameCnt < f0 + 16'(n); c++) @(posedge core_clk);
    if (frameCnt < f0 + 16'(n)) begin
      nFail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, frameCnt, f0 + 16'(n));
      wrap_up();
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 26563;
    nFail = 0;
    checkCount = 0;
    {rst, chipSelectN, readNotWrite} = 3'b111;
    {registerSelect, busStrobe, penArm} = 3'b000;
    dataIn = 8'h00;
    penTarget = 14'h0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    for (i = 0; i < 18; i++) rd(i[4:0], 8'h00);
    for (i = 0; i < 16; i++) begin
      if (i < 8 || i > 13) begin
        r = $random(seed);
        wr(i[4:0], r[7:0]);
        rd(i[4:0], r[7:0] & reg_mask(i[4:0]));
      end
    end
    wr(5'h10, 8'hff);
    rd(5'h10, 8'h00);
    wr(5'h15, 8'hff);
    rd(5'h15, 8'h00);
    // ignored index must leave the previous selection in force
    for (k = 8; k < 14; k++) begin
      r = $random(seed);
      bus_op(1'b0, 1'b0, 8'h01);
      bus_op(1'b0, 1'b0, k[7:0]);
      bus_op(1'b1, 1'b0, r[7:0]);
      rd(5'h01, r[7:0]);
    end
    wr(5'h00, 8'd39);
    wr(5'h01, 8'd20);
    wr(5'h02, 8'd22);
    wr(5'h04, 8'd39);
    wr(5'h06, 8'd16);
    wr(5'h07, 8'd20);
    wr(5'h0e, 8'h00);
    wr(5'h0f, 8'd67);
    penTarget <= 14'd104;
    penArm <= 1'b1;
    for (k = 0; k < 3; k++) begin
      r = $random(seed);
      hsync_width_field = (k == 0) ? 4'hf : (k == 1) ? 4'h1 : 4'(r[7:0] % 8'd15) + 4'h1;
      vsync_width_field = (k == 0) ? 4'h0 : (k == 1) ? 4'h1 : r[11:8];
      vadj = (k == 0) ? 5'h1f : (k == 1) ? 5'h00 : r[16:12];
      wr(5'h03, {vsync_width_field, hsync_width_field});
      wr(5'h05, {3'h0, vadj});
      wait_frames(3);
      chk_count(hsWidth, {12'h0, hsync_width_field});
      chk_count(hsPeriod, 16'd40);
      chk_count(hsLead, 16'd3);
      chk_count(vsWidth, exp_vs(vsync_width_field));
      chk_count(frPeriod, 16'((40 + vadj) * 40));
      chk_count(deLine, 16'd20);
      chk_count(curFrame, 16'd1);
      chk_count({15'h0, curBad}, 16'h0);
      chk_count({2'h0, firstAddr}, 16'h0);
      chk_count({11'h0, scanlineAddress}, 16'h0);
      get(5'h10);
      cap[15:8] = rdv;
      get(5'h11);
      cap[7:0] = rdv;
      chk_count({15'h0, cap >= 16'd105 && cap <= 16'd110}, 16'h1);
    end
    // reset in mid-run clears outputs and registers
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    #1;
    chk_count({15'h0, hsync}, 16'h0);
    chk_count({2'h0, refreshAddress}, 16'h0);
    @(posedge core_clk);
    rst <= 1'b0;
    rd(5'h03, 8'h00);
    wrap_up();
  end
endmodule // crt_raster_timing_control_tb
`default_nettype wire
